// >>> hw/card_status_rca_bank.sv
// Contract
// - Bit 16 is set when the host tries to make the copy flag original or clear the permanent lock; clears on read.
// - Bit 15 is set when an erase skipped write-protected blocks, and clears on read.
// - Bit 14 shows 1 when the command ran without internal correction and 0 when with it, updated as each command finishes.
// - Bits 12..9 hold the card state at command receipt; a state change shows only in the next command's response.
// - Bit 8 is 1 when the data buffer is empty and ready, matching the busy line, else 0.
// - The card holds a 16-bit relative address and publishes it during identification.
// - After identification the card answers only commands addressed with its relative address; the code also accepts every command with cmd_addressed low.
// - In SPI mode, besides the status word, only the card specific data and card identity registers are reachable.
// - In SPI mode those two registers keep the native field layout.
// - In SPI mode status is reported in a shorter format.
// - State bits follow the previous command and update on each valid command; clear-on-read bits clear when read.
`timescale 1ns/1ps
`default_nettype none
module card_status_rca_bank
   import card_status_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic cmd_strobe,
   input wire logic cmd_addressed,
   input wire logic [15:0] cmd_rca,
   input wire logic cmd_in_erase_seq,
   input wire logic erase_seq_open,
   input wire logic erase_exec,
   input wire logic overwrite_attempt,
   input wire logic erase_skip_evt,
   input wire logic cmd_done,
   input wire logic cmd_ecc_off,
   input wire logic state_change,
   input wire logic [3:0] new_state,
   input wire logic buffer_empty,
   input wire logic rca_load,
   input wire logic [15:0] rca_value,
   input wire logic spi_mode,
   input wire logic reg_read,
   input wire logic [1:0] reg_sel,
   output logic cmd_accept,
   output logic [15:0] relative_card_address,
   output logic busy_signal_line,
   output logic [31:0] read_data,
   output logic read_ack,
   output logic read_refused,
   output logic ident_grant
);
   typedef struct packed {
      logic [3:0] cur_state;
      logic [3:0] rep_state;
      logic [15:0] rca;
      logic rca_valid;
      logic erase_pend;
      logic ecc_off;
      logic ready;
      logic busy;
      logic accept;
      logic [31:0] rd_data;
      logic rd_ack;
      logic rd_refuse;
      logic grant;
   } bank_s;

   bank_s s_reg;
   bank_s s_next;
   status_evt_if ev ();

   function automatic logic [31:0] spi_short(input logic [31:0] w);
      logic [31:0] r;
      r = WORD_ZERO;
      r[SPI_BIT_IDLE] = (w[STATE_HI:STATE_LO] == ST_IDLE);
      r[SPI_BIT_ABORT] = w[BIT_ERASE_ABORT];
      r[SPI_BIT_OVERWRITE] = w[BIT_OVERWRITE];
      r[SPI_BIT_SKIP] = w[BIT_ERASE_SKIP];
      return r;
   endfunction : spi_short

   logic addr_ok;
   logic abort_now;
   logic status_rd;

   // Before identification no address is published, so addressed commands are ignored
   assign addr_ok = !cmd_addressed || (s_reg.rca_valid && cmd_rca == s_reg.rca);
   assign abort_now = cmd_strobe && addr_ok && s_reg.erase_pend && !cmd_in_erase_seq;
   assign status_rd = reg_read && reg_sel == SEL_STATUS;

   assign ev.overwrite_evt = overwrite_attempt;
   assign ev.skip_evt = erase_skip_evt;
   assign ev.abort_evt = abort_now;
   assign ev.ecc_off = s_reg.ecc_off;
   assign ev.rep_state = s_reg.rep_state;
   assign ev.ready_data = s_reg.ready;
   assign ev.clear_c = status_rd;

   status_lower_half u_low (
      .clk(clk),
      .rst(rst),
      .ev(ev)
   );

   always_comb begin
      s_next = s_reg;
      s_next.accept = cmd_strobe && addr_ok;
      s_next.rd_ack = 1'b0;
      s_next.rd_refuse = 1'b0;
      s_next.grant = 1'b0;
      // Report the state held when the command arrived; its own change shows next time
      if (cmd_strobe && addr_ok) begin
         s_next.rep_state = s_reg.cur_state;
      end
      if (state_change) begin
         s_next.cur_state = new_state;
      end
      if (cmd_done) begin
         s_next.ecc_off = cmd_ecc_off;
      end
      if (abort_now || erase_exec) begin
         s_next.erase_pend = 1'b0;
      end else if (erase_seq_open) begin
         s_next.erase_pend = 1'b1;
      end
      s_next.ready = buffer_empty;
      s_next.busy = !buffer_empty;
      if (rca_load) begin
         s_next.rca = rca_value;
         s_next.rca_valid = 1'b1;
      end
      if (reg_read) begin
         s_next.rd_data = WORD_ZERO;
         unique case (reg_sel)
            SEL_STATUS: begin
               // Status word is only sent on request, never pushed
               s_next.rd_data = spi_mode ? spi_short(ev.low_word) : ev.low_word;
               s_next.rd_ack = 1'b1;
            end
            SEL_RCA: begin
               if (spi_mode) begin
                  s_next.rd_refuse = 1'b1;
               end else begin
                  s_next.rd_data[RCA_W-1:0] = s_reg.rca;
                  s_next.rd_ack = 1'b1;
               end
            end
            SEL_CSD, SEL_CID: begin
               // Same grant in both modes so the stored layout is never reshuffled
               s_next.grant = 1'b1;
               s_next.rd_ack = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.cur_state <= ST_IDLE;
         s_reg.rep_state <= ST_IDLE;
         s_reg.rca <= RCA_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cmd_accept = s_reg.accept;
   assign relative_card_address = s_reg.rca;
   assign busy_signal_line = s_reg.busy;
   assign read_data = s_reg.rd_data;
   assign read_ack = s_reg.rd_ack;
   assign read_refused = s_reg.rd_refuse;
   assign ident_grant = s_reg.grant;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence change_then_cmd;
      state_change && !cmd_strobe ##1 cmd_strobe && addr_ok && !state_change;
   endsequence

   a_state_delayed: assert property (change_then_cmd |=> ev.rep_state == $past(new_state, 2))
      else $error("state change not shown in next response");
   a_state_at_rx: assert property (cmd_strobe && addr_ok |=> ev.rep_state == $past(s_reg.cur_state))
      else $error("reported state not captured at command receipt");
   a_wrong_rca: assert property (cmd_strobe && cmd_addressed && s_reg.rca_valid
      && cmd_rca != s_reg.rca |=> !cmd_accept)
      else $error("command with foreign address accepted");
   a_rca_publish: assert property (rca_load |=> relative_card_address == $past(rca_value))
      else $error("relative address not loaded");
   a_busy_match: assert property (1'b1 |=> busy_signal_line == !$past(buffer_empty) && busy_signal_line != ev.ready_data)
      else $error("ready bit and busy line disagree");
   a_ready_follow: assert property (buffer_empty |=> ev.ready_data && !busy_signal_line)
      else $error("ready bit does not follow empty buffer");
   a_spi_refuse: assert property (reg_read && spi_mode && reg_sel == SEL_RCA |=> read_refused && !read_ack)
      else $error("address register reachable in SPI mode");
   a_ident_grant: assert property (reg_read && reg_sel[1] |=> ident_grant && read_ack)
      else $error("identity or config register not granted");
   a_abort_flag: assert property (abort_now |=> ev.low_word[BIT_ERASE_ABORT]
      ##1 (ev.low_word[BIT_ERASE_ABORT] || $past(status_rd)))
      else $error("erase abort not flagged");
   a_ecc_track: assert property (cmd_done |=> ev.low_word[BIT_ECC_OFF] == $past(cmd_ecc_off))
      else $error("correction bit not following command");
   a_spi_short: assert property (status_rd && spi_mode |=> read_data[31:4] == 28'h0000000)
      else $error("SPI status not in short format");

   // The reported state may only move on an accepted command, never on the card's own change
   a_state_hold: assert property (!(cmd_strobe && addr_ok) |=> $stable(ev.rep_state))
      else $error("reported state moved without a command");
   a_unaddr_accept: assert property (cmd_strobe && !cmd_addressed |=> cmd_accept)
      else $error("unaddressed command not accepted");
   a_addr_match: assert property (cmd_strobe && cmd_addressed && s_reg.rca_valid
      && cmd_rca == s_reg.rca |=> cmd_accept)
      else $error("command with own address refused");
   a_read_answer: assert property (reg_read |=> read_ack != read_refused)
      else $error("read not answered exactly once");
   a_native_status: assert property (status_rd && !spi_mode |=> read_data[31:17] == 15'h0000
      && read_data[STATE_HI:STATE_LO] == $past(ev.rep_state))
      else $error("native status word malformed");
   a_refuse_data: assert property (reg_read && spi_mode && reg_sel == SEL_RCA |=> read_data == WORD_ZERO)
      else $error("refused read returned data");
   a_grant_select: assert property (reg_read && !reg_sel[1] |=> !ident_grant)
      else $error("storage grant on a local register read");
   a_ecc_hold: assert property (!cmd_done |=> $stable(ev.low_word[BIT_ECC_OFF]))
      else $error("correction bit moved without a finished command");
endmodule : card_status_rca_bank
`default_nettype wire

// >>> hw/status_lower_half.sv
`timescale 1ns/1ps
`default_nettype none
module status_lower_half
   import card_status_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   status_evt_if.bank ev
);
   typedef struct packed {
      logic overwrite;
      logic skip;
      logic abort;
   } sticky_s;

   sticky_s st_reg;
   sticky_s st_next;

   // Set wins over the clear-by-read so an event in the read cycle is kept
   always_comb begin
      st_next.overwrite = ev.overwrite_evt | (st_reg.overwrite & ~ev.clear_c);
      st_next.skip = ev.skip_evt | (st_reg.skip & ~ev.clear_c);
      st_next.abort = ev.abort_evt | (st_reg.abort & ~ev.clear_c);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Reserved bits and the upper half are held at zero here
   always_comb begin
      ev.low_word = WORD_ZERO;
      ev.low_word[BIT_OVERWRITE] = st_reg.overwrite;
      ev.low_word[BIT_ERASE_SKIP] = st_reg.skip;
      ev.low_word[BIT_ECC_OFF] = ev.ecc_off;
      ev.low_word[BIT_ERASE_ABORT] = st_reg.abort;
      ev.low_word[STATE_HI:STATE_LO] = ev.rep_state;
      ev.low_word[BIT_READY] = ev.ready_data;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_overwrite_sticky: assert property (ev.overwrite_evt |=> ev.low_word[BIT_OVERWRITE])
      else $error("overwrite event not recorded");
   a_skip_clear_read: assert property (ev.clear_c && !ev.skip_evt |=> !ev.low_word[BIT_ERASE_SKIP])
      else $error("erase skip bit survived a read");
   a_reserved_zero: assert property (ev.low_word[7:6] == 2'h0 && ev.low_word[4:0] == 5'h00)
      else $error("reserved status bits not zero");
endmodule : status_lower_half
`default_nettype wire

// >>> shared/card_status_pkg.sv
`default_nettype none
package card_status_pkg;
   localparam int STATUS_W = 32;
   localparam int RCA_W = 16;
   localparam int STATE_W = 4;
   // Lower half bit positions of the status word
   localparam int BIT_OVERWRITE = 16;
   localparam int BIT_ERASE_SKIP = 15;
   localparam int BIT_ECC_OFF = 14;
   localparam int BIT_ERASE_ABORT = 13;
   localparam int STATE_HI = 12;
   localparam int STATE_LO = 9;
   localparam int BIT_READY = 8;
   // Card state codes as reported in the status word
   localparam logic [3:0] ST_IDLE = 4'h0;
   localparam logic [3:0] ST_READY = 4'h1;
   localparam logic [3:0] ST_IDENT = 4'h2;
   localparam logic [3:0] ST_STBY = 4'h3;
   localparam logic [3:0] ST_TRAN = 4'h4;
   localparam logic [3:0] ST_DATA = 4'h5;
   localparam logic [3:0] ST_RCV = 4'h6;
   localparam logic [3:0] ST_PRG = 4'h7;
   localparam logic [3:0] ST_DIS = 4'h8;
   // Register select codes on the read port
   localparam logic [1:0] SEL_STATUS = 2'h0;
   localparam logic [1:0] SEL_RCA = 2'h1;
   localparam logic [1:0] SEL_CSD = 2'h2;
   localparam logic [1:0] SEL_CID = 2'h3;
   // Short status layout used in SPI mode
   localparam int SPI_BIT_IDLE = 0;
   localparam int SPI_BIT_ABORT = 1;
   localparam int SPI_BIT_OVERWRITE = 2;
   localparam int SPI_BIT_SKIP = 3;
   // Values after reset
   localparam logic [15:0] RCA_RESET = 16'h0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage : card_status_pkg
`default_nettype wire

// >>> shared/status_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface status_evt_if;
   logic overwrite_evt;
   logic skip_evt;
   logic abort_evt;
   logic ecc_off;
   logic [3:0] rep_state;
   logic ready_data;
   logic clear_c;
   logic [31:0] low_word;
   modport src (output overwrite_evt, output skip_evt, output abort_evt, output ecc_off, output rep_state,
                output ready_data, output clear_c, input low_word);
   modport bank (input overwrite_evt, input skip_evt, input abort_evt, input ecc_off, input rep_state,
                 input ready_data, input clear_c, output low_word);
endinterface : status_evt_if
`default_nettype wire

// >>> sim/host_cmd_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
   input wire logic clk,
   input wire logic cmd_accept,
   output logic cmd_strobe,
   output logic cmd_addressed,
   output logic [15:0] cmd_rca,
   output logic cmd_in_erase_seq
);
   initial begin
      cmd_strobe = 1'b0;
      cmd_addressed = 1'b0;
      cmd_rca = 16'h0000;
      cmd_in_erase_seq = 1'b0;
   end
   // Qualifiers are inverted after the strobe so a stale value can never look valid
   task automatic issue(input logic adr, input logic [15:0] rca, input logic ers, output logic acc);
      @(negedge clk);
      cmd_strobe = 1'b1;
      cmd_addressed = adr;
      cmd_rca = rca;
      cmd_in_erase_seq = ers;
      @(negedge clk);
      acc = cmd_accept;
      cmd_strobe = 1'b0;
      cmd_addressed = ~adr;
      cmd_rca = ~rca;
      cmd_in_erase_seq = ~ers;
   endtask : issue
endmodule : host_cmd_model
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import card_status_pkg::*;
   logic clk, rst, cmd_strobe, cmd_addressed, cmd_in_erase_seq, erase_seq_open, erase_exec;
   logic overwrite_attempt, erase_skip_evt, cmd_done, cmd_ecc_off, state_change, buffer_empty;
   logic rca_load, spi_mode, reg_read, cmd_accept, busy_signal_line, read_ack, read_refused, ident_grant;
   logic [15:0] cmd_rca, rca_value, relative_card_address;
   logic [3:0] new_state;
   logic [1:0] reg_sel;
   logic [31:0] read_data;
   logic m_ow, m_skip, m_ecc, m_abort, m_pend, m_loaded;
   logic [3:0] m_state, m_card;
   logic [15:0] m_rca;
   int n_fail, n_checks;
   card_status_rca_bank i_dut (.clk(clk), .rst(rst), .cmd_strobe(cmd_strobe), .cmd_addressed(cmd_addressed),
      .cmd_rca(cmd_rca), .cmd_in_erase_seq(cmd_in_erase_seq), .erase_seq_open(erase_seq_open),
      .erase_exec(erase_exec), .overwrite_attempt(overwrite_attempt), .erase_skip_evt(erase_skip_evt),
      .cmd_done(cmd_done), .cmd_ecc_off(cmd_ecc_off), .state_change(state_change), .new_state(new_state),
      .buffer_empty(buffer_empty), .rca_load(rca_load), .rca_value(rca_value), .spi_mode(spi_mode),
      .reg_read(reg_read), .reg_sel(reg_sel), .cmd_accept(cmd_accept),
      .relative_card_address(relative_card_address), .busy_signal_line(busy_signal_line),
      .read_data(read_data), .read_ack(read_ack), .read_refused(read_refused), .ident_grant(ident_grant));
   host_cmd_model i_host (.clk(clk), .cmd_accept(cmd_accept), .cmd_strobe(cmd_strobe),
      .cmd_addressed(cmd_addressed), .cmd_rca(cmd_rca), .cmd_in_erase_seq(cmd_in_erase_seq));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask : chk
   task automatic close_out();
      $display("checks=%0d failures=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   function automatic logic [31:0] exp_word();
      if (spi_mode) return {28'h0, m_skip, m_ow, m_abort, m_state == ST_IDLE};
      return {15'h0, m_ow, m_skip, m_ecc, m_abort, m_state, buffer_empty, 8'h00};
   endfunction : exp_word
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   task automatic rd(input logic [1:0] sel);
      logic rf;
      logic [31:0] ew;
      rf = spi_mode && sel == SEL_RCA;
      ew = exp_word();
      @(negedge clk);
      reg_read = 1'b1;
      reg_sel = sel;
      @(negedge clk);
      reg_read = 1'b0;
      chk({read_ack, read_refused}, {!rf, rf});
      chk({31'h0, ident_grant}, {31'h0, sel[1]});
      if (rf) chk(read_data, WORD_ZERO);
      else if (sel == SEL_RCA) chk(read_data, {16'h0, m_rca});
      else if (sel == SEL_STATUS) chk(read_data & 32'hFFFF_FFDF, ew);
      if (sel == SEL_STATUS) {m_ow, m_skip, m_abort} = 3'b000;
   endtask : rd
   task automatic cmd(input logic adr, input logic [15:0] a, input logic ers);
      logic acc, e;
      e = !adr || (m_loaded && a === m_rca);
      i_host.issue(adr, a, ers, acc);
      chk({31'h0, acc}, {31'h0, e});
      if (e) begin
         m_state = m_card;
         if (m_pend && !ers) {m_abort, m_pend} = 2'b10;
      end
   endtask : cmd
   initial begin
      {rst, erase_seq_open, erase_exec, overwrite_attempt, erase_skip_evt, cmd_done, cmd_ecc_off} = 7'h41;
      {state_change, rca_load, spi_mode, reg_read, new_state, rca_value, reg_sel} = '0;
      buffer_empty = 1'b1;
      {m_ow, m_skip, m_ecc, m_abort, m_pend, m_loaded, m_state, m_card, m_rca} = '0;
      n_fail = 0;
      n_checks = 0;
      void'($urandom(32'hdd9b8273));
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      chk({16'h0, relative_card_address}, {16'h0, RCA_RESET});
      rd(SEL_STATUS);
      cmd(1'b1, 16'($urandom), 1'b0);
      cmd(1'b0, 16'h0000, 1'b0);
      rca_value = 16'($urandom);
      m_rca = rca_value;
      m_loaded = 1'b1;
      pulse(rca_load);
      chk({16'h0, relative_card_address}, {16'h0, m_rca});
      rd(SEL_RCA);
      cmd(1'b1, m_rca, 1'b0);
      cmd(1'b1, m_rca ^ 16'h0001, 1'b0);
      // Card state change directly followed by a command
      new_state = ST_TRAN;
      m_card = ST_TRAN;
      fork
         pulse(state_change);
         begin
            @(negedge clk);
            cmd(1'b0, 16'h0000, 1'b0);
         end
      join
      rd(SEL_STATUS);
      for (int s = 8; s >= 0; s--) begin
         new_state = 4'(s);
         m_card = new_state;
         pulse(state_change);
         rd(SEL_STATUS);
         cmd(1'b1, m_rca, 1'b0);
         rd(SEL_STATUS);
      end
      for (int b = 0; b < 4; b++) begin
         @(negedge clk);
         buffer_empty = (b == 0) ? 1'b0 : 1'($urandom);
         @(negedge clk);
         chk({31'h0, busy_signal_line}, {31'h0, !buffer_empty});
         rd(SEL_STATUS);
      end
      for (int e = 1; e >= 0; e--) begin
         cmd_ecc_off = 1'(e);
         m_ecc = 1'(e);
         pulse(cmd_done);
         rd(SEL_STATUS);
      end
      m_ow = 1'b1;
      pulse(overwrite_attempt);
      rd(SEL_STATUS);
      rd(SEL_STATUS);
      m_skip = 1'b1;
      pulse(erase_skip_evt);
      rd(SEL_STATUS);
      rd(SEL_STATUS);
      m_pend = 1'b1;
      pulse(erase_seq_open);
      cmd(1'b0, 16'h0000, 1'b1);
      cmd(1'b0, 16'h0000, 1'b0);
      rd(SEL_STATUS);
      rd(SEL_STATUS);
      pulse(erase_seq_open);
      pulse(erase_exec);
      cmd(1'b0, 16'h0000, 1'b0);
      rd(SEL_STATUS);
      for (int m = 0; m < 2; m++) begin
         spi_mode = 1'(m);
         m_skip = 1'b1;
         m_ow = 1'b1;
         pulse(erase_skip_evt);
         pulse(overwrite_attempt);
         for (int r = 0; r < 4; r++) rd(2'(r));
      end
      // Reset in mid-run must forget the published address and all sticky bits
      spi_mode = 1'b0;
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      chk({15'h0, busy_signal_line, relative_card_address}, WORD_ZERO);
      chk({30'h0, read_ack, cmd_accept}, WORD_ZERO);
      rst = 1'b0;
      {m_ow, m_skip, m_ecc, m_abort, m_pend, m_loaded, m_state, m_card, m_rca} = '0;
      cmd(1'b1, 16'h0000, 1'b0);
      rd(SEL_STATUS);
      close_out();
   end
   initial begin
      repeat (5000) @(posedge clk);
      $display("ERROR t=%0t cycles=%h limit=%h", $time, 5000, 5000);
      n_fail++;
      close_out();
   end
endmodule : testbench
`default_nettype wire
